// ---- include/swb_defs.svh ----
// Constants for the serial debug port write buffer and ack selector.
// Assumes inclusion by bare name from each design file.
// Functional notes
// - Buffered write fitting the buffer gets OK
// - Keep issue order; stall port writes behind buffer
// - Dropping an accepted write sets payload error
// - Any sticky flag drops pending buffered writes
// - Ident/status read immediate, flushes, sets error
// - Abort write never stalls, drops buffer
// - Buffer busy: WAIT access reads, most port ops
// - Pushed modes turn access writes into reads
// - Port register chosen by address, bank select
// - Ident and status reads always OK
// - Other reads: FAULT, WAIT, else OK
// - Resend address returns last sent value
// - Read buffer returns previous result, sets valid
// - Read buffer WAIT/FAULT clears read valid
// - Overrun detection keeps data phase on WAIT/FAULT
// - Abort bits clear matching sticky flags
`ifndef SWB_DEFS_SVH
`define SWB_DEFS_SVH

`define SWB_ACK_OK 3'h1
`define SWB_ACK_WAIT 3'h2
`define SWB_ACK_FAULT 3'h4

`define SWB_A_IDENT 2'h0
`define SWB_A_ABORT 2'h0
`define SWB_A_CS 2'h1
`define SWB_A_RESEND 2'h2
`define SWB_A_SELECT 2'h2
`define SWB_A_RDBUF 2'h3
`define SWB_BANK_CS 4'h0
`define SWB_BANK_W 4

`define SWB_ABT_DAP 0
`define SWB_ABT_ERRCLR 2
`define SWB_ABT_WDCLR 3
`define SWB_ABT_ORCLR 4

`define SWB_CS_ORUNEN 0
`define SWB_CS_ORUN 1
`define SWB_CS_ERR 5
`define SWB_CS_READ_VALID_FLAG 6
`define SWB_CS_WDERR 7

// Arbitrary identification value
`define SWB_IDENT_VALUE 32'h1234_5671

`define SWB_WBUF_DEPTH 3'h4
`define SWB_WBUF_PW 2
`define SWB_WBUF_CW 3
`define SWB_WBUF_DP 1'h0
`define SWB_ENTRY_W 35
`define SWB_E_DP 34
`define SWB_E_ADDR 33:32

`define SWB_LINK_W 38
`define SWB_L_CLK 37
`define SWB_L_VALID 36
`define SWB_L_AP 35
`define SWB_L_RNW 34
`define SWB_L_ADDR 33:32

`define SWB_OFS_IRQ_STATUS 5'h00
`define SWB_OFS_IRQ_CLEAR 5'h04
`define SWB_OFS_IRQ_ENABLE 5'h08
`define SWB_OFS_CONFIG 5'h0C
`define SWB_OFS_STATE 5'h10

`define SWB_IRQ_W 3
`define SWB_IRQ_DROP 0
`define SWB_IRQ_FAULT 1
`define SWB_IRQ_WAIT 2

`define SWB_CFG_W 3
`define SWB_CFG_PUSHED 0
`define SWB_CFG_ORUN 1
`define SWB_CFG_V1 2
`define SWB_CFG_RESET 3'h4

`endif

// ---- include/swb_pkg.sv ----
// Types shared by the debug port write buffer and ack selector.
// Assumes swb_defs.svh supplies all numeric constants.
package swb_pkg;
   typedef logic [31:0] swb_word_t;
   typedef enum logic [3:0] {
      K_NONE, K_IDENT_RD, K_CS_RD, K_ABORT, K_DP_RD,
      K_RESEND, K_RDBUF, K_DP_WR, K_AP_RD, K_AP_WR
   } swb_kind_t;
endpackage : swb_pkg

// ---- verilog/swb_wbuf.sv ----
// In-order write buffer for the debug port.
// Assumes the owner never pushes and flushes in one cycle.
`timescale 1ns/100ps
`include "swb_defs.svh"
module swb_wbuf
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic push,
   input wire logic [`SWB_ENTRY_W-1:0] push_entry,
   input wire logic pop,
   input wire logic flush,
   output logic [`SWB_ENTRY_W-1:0] head,
   output logic empty,
   output logic full,
   output logic [`SWB_WBUF_CW-1:0] count
);
   logic [`SWB_ENTRY_W-1:0] mem [`SWB_WBUF_DEPTH];
   logic [`SWB_WBUF_PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [`SWB_WBUF_CW-1:0] next_count;
   logic do_push, do_pop;

   always_comb
   begin
      empty = count == '0;
      full = count == `SWB_WBUF_DEPTH;
      head = mem[rd_ptr];
      do_push = push & ~full & ~flush;
      do_pop = pop & ~empty & ~flush;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      // Dropped entries vanish at once; ordering is pointer based
      if (flush)
      begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = '0;
      end
      else
      begin
         if (do_push)
            next_wr_ptr = wr_ptr + 1'b1;
         if (do_pop)
            next_rd_ptr = rd_ptr + 1'b1;
         next_count = count + `SWB_WBUF_CW'(do_push)
            - `SWB_WBUF_CW'(do_pop);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (do_push)
         mem[wr_ptr] <= push_entry;
   end
endmodule : swb_wbuf

// ---- verilog/swb_top.sv ----
// Debug port write buffering and acknowledge selection.
// Assumes a packet decoder presents requests on the link clock,
// an access port handshake, and an Avalon-MM master for software.
`timescale 1ns/100ps
`include "swb_defs.svh"
module swb_top
(
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic LINK_CLK,
   input wire logic REQ_VALID,
   input wire logic REQ_AP,
   input wire logic REQ_RNW,
   input wire logic [1:0] REQ_ADDR,
   input wire swb_pkg::swb_word_t REQ_WDATA,
   output logic ACK_VALID,
   output logic [2:0] ACK,
   output logic ACK_DATA_PHASE,
   output swb_pkg::swb_word_t RDATA,
   output logic AP_REQ,
   output logic AP_RNW,
   output logic [1:0] AP_ADDR,
   output swb_pkg::swb_word_t AP_WDATA,
   input wire logic AP_DONE,
   input wire logic AP_ERR,
   input wire swb_pkg::swb_word_t AP_RDATA,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire swb_pkg::swb_word_t AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output swb_pkg::swb_word_t AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic IRQ
);
   import swb_pkg::*;

   logic [`SWB_LINK_W-1:0] sync1, sync2, sync3;
   logic link_lvl, next_link_lvl, link_stable, req_take;
   logic q_ap, q_rnw;
   logic [1:0] q_addr;
   swb_word_t q_wdata;
   swb_kind_t kind;
   logic bank_cs;

   logic [`SWB_BANK_W-1:0] bank, next_bank;
   logic [2:0] next_ack, reply;
   logic next_ack_valid, next_dphase, next_read_valid_flag, read_valid_flag;
   swb_word_t next_rdata, last_sent, next_last, ap_result;
   swb_word_t next_ap_result, next_ap_wdata, cs_value;
   logic next_ap_req, next_ap_rnw;
   logic [1:0] next_ap_addr;
   logic wderr, st_err, st_orun, next_wderr, next_err, next_orun;
   logic sticky, idle, clr_err, clr_wd, clr_orun, set_orun;
   logic push, pop, flush, flush_req, ev_drop;
   logic [`SWB_ENTRY_W-1:0] push_entry, buf_head;
   logic buf_empty, buf_full;
   logic [`SWB_WBUF_CW-1:0] buf_count;
   logic [`SWB_IRQ_W-1:0] events, irq_st, next_irq_st, irq_en, next_en;
   logic [`SWB_IRQ_W-1:0] irq_clr;
   logic [`SWB_CFG_W-1:0] cfg, next_cfg;
   logic next_wait, next_irq;
   swb_word_t next_avs_rd;

   // Link clock is sampled; a change counts when stages two, three agree
   always_comb
   begin
      link_stable = sync2[`SWB_L_CLK] == sync3[`SWB_L_CLK];
      next_link_lvl = link_stable ? sync3[`SWB_L_CLK] : link_lvl;
      req_take = link_stable & sync3[`SWB_L_CLK] & ~link_lvl
         & sync3[`SWB_L_VALID];
      q_ap = sync3[`SWB_L_AP];
      q_rnw = sync3[`SWB_L_RNW];
      q_addr = sync3[`SWB_L_ADDR];
      q_wdata = sync3[31:0];
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         link_lvl <= 1'b0;
      end
      else
      begin
         sync1 <= {LINK_CLK, REQ_VALID, REQ_AP, REQ_RNW, REQ_ADDR,
            REQ_WDATA};
         sync2 <= sync1;
         sync3 <= sync2;
         link_lvl <= next_link_lvl;
      end
   end

   // Request decode
   always_comb
   begin
      bank_cs = ~cfg[`SWB_CFG_V1] | (bank == `SWB_BANK_CS);
      kind = K_NONE;
      if (req_take)
      begin
         if (q_ap)
            kind = (q_rnw | cfg[`SWB_CFG_PUSHED]) ? K_AP_RD
               : K_AP_WR;
         else if (!q_rnw)
            kind = (q_addr == `SWB_A_ABORT) ? K_ABORT : K_DP_WR;
         else
         begin
            unique case (q_addr)
               `SWB_A_IDENT: kind = K_IDENT_RD;
               `SWB_A_CS: kind = bank_cs ? K_CS_RD : K_DP_RD;
               `SWB_A_RESEND: kind = K_RESEND;
               `SWB_A_RDBUF: kind = K_RDBUF;
            endcase
         end
      end
   end

   swb_wbuf u_wbuf
   (
      .clock(CLOCK),
      .rst_b(RST_B),
      .push(push),
      .push_entry(push_entry),
      .pop(pop),
      .flush(flush),
      .head(buf_head),
      .empty(buf_empty),
      .full(buf_full),
      .count(buf_count)
   );

   // Ack selection, buffer control, sticky flags
   always_comb
   begin
      sticky = wderr | st_err | st_orun;
      idle = buf_empty & ~AP_REQ;
      cs_value = '0;
      cs_value[`SWB_CS_ORUNEN] = cfg[`SWB_CFG_ORUN];
      cs_value[`SWB_CS_ORUN] = st_orun;
      cs_value[`SWB_CS_ERR] = st_err;
      cs_value[`SWB_CS_READ_VALID_FLAG] = read_valid_flag;
      cs_value[`SWB_CS_WDERR] = wderr;
      next_ack = ACK;
      next_ack_valid = 1'b0;
      next_dphase = ACK_DATA_PHASE;
      next_rdata = RDATA;
      next_last = last_sent;
      next_ap_result = ap_result;
      next_read_valid_flag = read_valid_flag;
      next_bank = bank;
      next_ap_req = AP_REQ;
      next_ap_rnw = AP_RNW;
      next_ap_addr = AP_ADDR;
      next_ap_wdata = AP_WDATA;
      clr_err = 1'b0;
      clr_wd = 1'b0;
      clr_orun = 1'b0;
      set_orun = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      flush_req = 1'b0;
      push_entry = {~q_ap, q_addr, q_wdata};
      reply = `SWB_ACK_OK;
      unique case (kind)
         K_NONE: ;
         K_IDENT_RD, K_CS_RD: flush_req = 1'b1;
         K_ABORT:
         begin
            flush_req = 1'b1;
            clr_err = q_wdata[`SWB_ABT_ERRCLR];
            clr_wd = q_wdata[`SWB_ABT_WDCLR];
            clr_orun = q_wdata[`SWB_ABT_ORCLR];
         end
         default:
            if (sticky)
               reply = `SWB_ACK_FAULT;
            else if (kind == K_AP_WR || (kind == K_DP_WR && `SWB_WBUF_DP))
               reply = buf_full ? `SWB_ACK_WAIT : `SWB_ACK_OK;
            else if (!idle)
               reply = `SWB_ACK_WAIT;
      endcase
      if (req_take)
      begin
         next_ack_valid = 1'b1;
         next_ack = reply;
         // Overrun detection keeps the data slot on refusals
         next_dphase = (reply == `SWB_ACK_OK) ? q_rnw
            : cfg[`SWB_CFG_ORUN];
         set_orun = (reply != `SWB_ACK_OK) & cfg[`SWB_CFG_ORUN];
         if (kind == K_RDBUF || kind == K_AP_RD)
            next_read_valid_flag = reply == `SWB_ACK_OK;
         if (reply == `SWB_ACK_OK)
         begin
            unique case (kind)
               K_IDENT_RD: next_rdata = `SWB_IDENT_VALUE;
               K_CS_RD: next_rdata = cs_value;
               K_DP_RD: next_rdata = swb_word_t'(bank);
               K_RESEND: next_rdata = last_sent;
               K_RDBUF:
               begin
                  next_rdata = ap_result;
                  next_last = ap_result;
               end
               K_AP_RD:
               begin
                  next_rdata = ap_result;
                  next_last = ap_result;
                  next_ap_req = 1'b1;
                  next_ap_rnw = 1'b1;
                  next_ap_addr = q_addr;
               end
               K_AP_WR: push = 1'b1;
               K_DP_WR:
                  if (`SWB_WBUF_DP)
                     push = 1'b1;
                  else if (q_addr == `SWB_A_SELECT)
                     next_bank = q_wdata[`SWB_BANK_W-1:0];
               default: ;
            endcase
         end
      end
      // Pending writes die once any sticky flag is up
      flush = (flush_req | sticky) & ~buf_empty;
      ev_drop = flush;
      // Head drains only when nothing is outstanding, keeping order
      if (!AP_REQ && !buf_empty && !flush)
      begin
         pop = 1'b1;
         if (buf_head[`SWB_E_DP])
         begin
            if (buf_head[`SWB_E_ADDR] == `SWB_A_SELECT)
               next_bank = buf_head[`SWB_BANK_W-1:0];
         end
         else
         begin
            next_ap_req = 1'b1;
            next_ap_rnw = 1'b0;
            next_ap_addr = buf_head[`SWB_E_ADDR];
            next_ap_wdata = buf_head[31:0];
         end
      end
      if (AP_REQ && AP_DONE)
      begin
         next_ap_req = 1'b0;
         if (AP_RNW)
            next_ap_result = AP_RDATA;
      end
      // Abort frees the access port even mid transfer
      if (kind == K_ABORT && q_wdata[`SWB_ABT_DAP])
         next_ap_req = 1'b0;
      // Set wins over a clear in the same cycle
      next_err = (st_err & ~clr_err) | (AP_REQ & AP_DONE & AP_ERR);
      next_wderr = (wderr & ~clr_wd) | ev_drop;
      next_orun = (st_orun & ~clr_orun) | set_orun;
      events = '0;
      events[`SWB_IRQ_DROP] = ev_drop;
      events[`SWB_IRQ_FAULT] = req_take & (reply == `SWB_ACK_FAULT);
      events[`SWB_IRQ_WAIT] = req_take & (reply == `SWB_ACK_WAIT);
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         ACK <= `SWB_ACK_OK;
         ACK_VALID <= 1'b0;
         ACK_DATA_PHASE <= 1'b0;
         RDATA <= '0;
         last_sent <= '0;
         ap_result <= '0;
         read_valid_flag <= 1'b0;
         bank <= `SWB_BANK_CS;
         AP_REQ <= 1'b0;
         AP_RNW <= 1'b0;
         AP_ADDR <= '0;
         AP_WDATA <= '0;
         wderr <= 1'b0;
         st_err <= 1'b0;
         st_orun <= 1'b0;
      end
      else
      begin
         ACK <= next_ack;
         ACK_VALID <= next_ack_valid;
         ACK_DATA_PHASE <= next_dphase;
         RDATA <= next_rdata;
         last_sent <= next_last;
         ap_result <= next_ap_result;
         read_valid_flag <= next_read_valid_flag;
         bank <= next_bank;
         AP_REQ <= next_ap_req;
         AP_RNW <= next_ap_rnw;
         AP_ADDR <= next_ap_addr;
         AP_WDATA <= next_ap_wdata;
         wderr <= next_wderr;
         st_err <= next_err;
         st_orun <= next_orun;
      end
   end

   // Avalon slave: every access answers on the second cycle
   always_comb
   begin
      next_wait = ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
      next_avs_rd = AVS_READDATA;
      next_en = irq_en;
      next_cfg = cfg;
      irq_clr = '0;
      if (AVS_READ && AVS_WAITREQUEST)
      begin
         case (AVS_ADDRESS)
            `SWB_OFS_IRQ_STATUS: next_avs_rd = swb_word_t'(irq_st);
            `SWB_OFS_IRQ_ENABLE: next_avs_rd = swb_word_t'(irq_en);
            `SWB_OFS_CONFIG: next_avs_rd = swb_word_t'(cfg);
            `SWB_OFS_STATE: next_avs_rd = {16'h0000, bank, 1'h0,
               buf_count, 3'h0, AP_REQ, read_valid_flag, st_orun, st_err, wderr};
            default: next_avs_rd = '0;
         endcase
      end
      if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0])
      begin
         case (AVS_ADDRESS)
            `SWB_OFS_IRQ_CLEAR: irq_clr = AVS_WRITEDATA[`SWB_IRQ_W-1:0];
            `SWB_OFS_IRQ_ENABLE: next_en = AVS_WRITEDATA[`SWB_IRQ_W-1:0];
            `SWB_OFS_CONFIG: next_cfg = AVS_WRITEDATA[`SWB_CFG_W-1:0];
            default: ;
         endcase
      end
      next_irq_st = (irq_st & ~irq_clr) | events;
      next_irq = |(next_irq_st & next_en);
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= '0;
         irq_en <= '0;
         irq_st <= '0;
         cfg <= `SWB_CFG_RESET;
         IRQ <= 1'b0;
      end
      else
      begin
         AVS_WAITREQUEST <= next_wait;
         AVS_READDATA <= next_avs_rd;
         irq_en <= next_en;
         irq_st <= next_irq_st;
         cfg <= next_cfg;
         IRQ <= next_irq;
      end
   end

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_B);

   a_ident_ok:
   assert property (req_take && kind == K_IDENT_RD |=> ACK_VALID
      && ACK == `SWB_ACK_OK && RDATA == `SWB_IDENT_VALUE)
      else $error("Ident read not answered OK");
   a_cs_rd_drop:
   assert property (req_take && kind == K_CS_RD && !buf_empty
      |=> ACK == `SWB_ACK_OK && wderr && buf_empty)
      else $error("Status read did not drop buffer");
   a_abort_clear:
   assert property (req_take && kind == K_ABORT && buf_empty
      && q_wdata[`SWB_ABT_WDCLR] |=> !wderr && ACK == `SWB_ACK_OK)
      else $error("Abort did not clear payload error");
   a_sticky_drop:
   assert property (sticky && !buf_empty |=> buf_empty && wderr)
      else $error("Sticky flag left writes pending");
   a_ap_wr_ok:
   assert property (req_take && kind == K_AP_WR && !sticky
      && !buf_full |=> ACK == `SWB_ACK_OK && !buf_empty)
      else $error("Fitting write not accepted");
   a_ap_rd_wait:
   assert property (req_take && kind == K_AP_RD && !sticky
      && !buf_empty |=> ACK == `SWB_ACK_WAIT ##1 !ACK_VALID)
      else $error("Access read not stalled");
   a_dp_wr_stall:
   assert property (req_take && kind == K_DP_WR && !sticky
      && !buf_empty && !`SWB_WBUF_DP |=> ACK == `SWB_ACK_WAIT)
      else $error("Port write passed buffered writes");
   a_rdbuf_ok:
   assert property (req_take && kind == K_RDBUF && !sticky && idle
      |=> ACK == `SWB_ACK_OK && read_valid_flag && RDATA == $past(ap_result))
      else $error("Read buffer result wrong");
   a_rdbuf_clr:
   assert property (req_take && kind == K_RDBUF && sticky
      |=> ACK == `SWB_ACK_FAULT && !read_valid_flag)
      else $error("Read valid not cleared");
   a_resend_val:
   assert property (req_take && kind == K_RESEND && !sticky && idle
      |=> RDATA == $past(last_sent))
      else $error("Resend value wrong");
   a_data_phase:
   assert property (ACK_VALID && ACK != `SWB_ACK_OK
      |-> ACK_DATA_PHASE == $past(cfg[`SWB_CFG_ORUN]))
      else $error("Data phase flag wrong on refusal");
endmodule : swb_top

// ---- verif/swb_host_model.sv ----
// Debug host model: drives link requests and captures each answer.
// Assumes the bench calls xfer and reads got_ack, got_dp and got_data.
`timescale 1ns/100ps
`include "swb_defs.svh"
module swb_host_model
(
   input wire logic clock,
   input wire logic ack_valid,
   input wire logic [2:0] ack,
   input wire logic data_phase,
   input wire swb_pkg::swb_word_t rdata,
   output logic link_clk,
   output logic req_valid,
   output logic req_ap,
   output logic req_rnw,
   output logic [1:0] req_addr,
   output swb_pkg::swb_word_t req_wdata
);
   import swb_pkg::*;
   logic [2:0] got_ack;
   logic got_dp;
   swb_word_t got_data;
   int n_ack;
   initial
   begin
      link_clk = 1'b0;
      req_valid = 1'b0;
      req_ap = 1'b0;
      req_rnw = 1'b0;
      req_addr = 2'h0;
      req_wdata = 32'h0000_0000;
      n_ack = 0;
   end
   // Answer fields are taken in the pulse cycle only
   always @(posedge clock)
      if (ack_valid === 1'b1)
      begin
         got_ack <= ack;
         got_dp <= data_phase;
         // Data with WAIT or FAULT is recorded as unknown
         got_data <= (ack === `SWB_ACK_OK) ? rdata : 32'hxxxx_xxxx;
         n_ack <= n_ack + 1;
      end
   // Link clock stands still between requests
   task automatic xfer(input logic ap, input logic rnw, input logic [1:0] a,
                       input swb_word_t wd, output logic ok);
      int seen;
      int k;
      seen = n_ack;
      @(posedge clock);
      req_valid <= 1'b1;
      req_ap <= ap;
      req_rnw <= rnw;
      req_addr <= a;
      req_wdata <= wd;
      // Half a link period is four system clocks
      repeat (4) @(posedge clock);
      link_clk <= 1'b1;
      repeat (4) @(posedge clock);
      link_clk <= 1'b0;
      // Released address and data lines show inverted values, not a stale copy
      req_valid <= 1'b0;
      req_wdata <= ~wd;
      req_addr <= ~a;
      k = 0;
      while (n_ack == seen && k < 40)
      begin
         @(posedge clock);
         k++;
      end
      ok = (n_ack != seen);
   endtask : xfer
endmodule : swb_host_model

// ---- verif/swb_top_tb.sv ----
// Self-checking bench for the write buffer and acknowledge selector.
// Assumes the host model drives the link and this bench plays access port.
`timescale 1ns/100ps
`include "swb_defs.svh"
module swb_top_tb;
   import swb_pkg::*;
   localparam logic [2:0] A_OK = `SWB_ACK_OK;
   localparam logic [2:0] A_WT = `SWB_ACK_WAIT;
   localparam logic [2:0] A_FT = `SWB_ACK_FAULT;
   logic CLOCK, RST_B, LINK_CLK, REQ_VALID, REQ_AP, REQ_RNW, IRQ;
   logic [1:0] REQ_ADDR, AP_ADDR;
   swb_word_t REQ_WDATA, RDATA, AP_WDATA, AP_RDATA, AVS_WRITEDATA;
   swb_word_t AVS_READDATA, r, r1, q, ap_res;
   logic ACK_VALID, ACK_DATA_PHASE, AP_REQ, AP_RNW, AP_DONE, AP_ERR;
   logic [2:0] ACK;
   logic [4:0] AVS_ADDRESS;
   logic AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
   logic [3:0] AVS_BYTEENABLE;
   logic ap_stall, ap_err, last_rnw, ok;
   int fail_count, n_compared, seed, ap_wait, k, n;
   swb_word_t wq[$], eq[$];
   swb_top DUT (.CLOCK(CLOCK), .RST_B(RST_B), .LINK_CLK(LINK_CLK),
      .REQ_VALID(REQ_VALID), .REQ_AP(REQ_AP), .REQ_RNW(REQ_RNW),
      .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .ACK_VALID(ACK_VALID),
      .ACK(ACK), .ACK_DATA_PHASE(ACK_DATA_PHASE), .RDATA(RDATA),
      .AP_REQ(AP_REQ), .AP_RNW(AP_RNW), .AP_ADDR(AP_ADDR),
      .AP_WDATA(AP_WDATA), .AP_DONE(AP_DONE), .AP_ERR(AP_ERR),
      .AP_RDATA(AP_RDATA), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));
   swb_host_model host (.clock(CLOCK), .ack_valid(ACK_VALID), .ack(ACK),
      .data_phase(ACK_DATA_PHASE), .rdata(RDATA), .link_clk(LINK_CLK),
      .req_valid(REQ_VALID), .req_ap(REQ_AP), .req_rnw(REQ_RNW),
      .req_addr(REQ_ADDR), .req_wdata(REQ_WDATA));
   initial
   begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end
   // Access port: random latency, stall on demand, logs completed writes
   always @(posedge CLOCK)
   begin
      AP_DONE <= 1'b0;
      AP_RDATA <= ~AP_RDATA;
      if (AP_REQ === 1'b1 && AP_DONE !== 1'b1 && !ap_stall)
      begin
         if (ap_wait > 0)
            ap_wait <= ap_wait - 1;
         else
         begin
            r = $random(seed);
            AP_DONE <= 1'b1;
            AP_ERR <= ap_err;
            AP_RDATA <= r;
            ap_wait <= r[9:8];
            last_rnw <= AP_RNW;
            if (AP_RNW)
               ap_res <= r;
            else
               wq.push_back(AP_WDATA);
         end
      end
   end
   function automatic swb_word_t st_exp(input logic wd, input logic er);
      return {30'h0, er, wd};
   endfunction : st_exp
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic timeout();
      fail_count++;
      $display("[ERR] %0t wait ran out", $time);
      print_verdict();
   endtask : timeout
   task automatic check(input swb_word_t seen, input swb_word_t exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Waitrequest and read data are taken at the edge that ends the access
   task automatic av(input logic wr, input logic [4:0] a, input swb_word_t d,
                     output swb_word_t rd);
      int j;
      @(posedge CLOCK);
      AVS_ADDRESS <= a;
      AVS_WRITE <= wr;
      AVS_READ <= ~wr;
      AVS_WRITEDATA <= d;
      j = 0;
      do
      begin
         @(posedge CLOCK);
         j++;
      end
      while (AVS_WAITREQUEST !== 1'b0 && j < 20);
      rd = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
      if (AVS_WAITREQUEST !== 1'b0)
         timeout();
   endtask : av
   task automatic st(input swb_word_t m, input swb_word_t e);
      av(1'b0, `SWB_OFS_STATE, 32'h0000_0000, q);
      check(q & m, e);
   endtask : st
   task automatic req(input logic ap, input logic rnw, input logic [1:0] a,
                      input swb_word_t wd, input logic [2:0] ea);
      host.xfer(ap, rnw, a, wd, ok);
      if (!ok)
         timeout();
      check({29'h0, host.got_ack}, {29'h0, ea});
   endtask : req
   // Idle means no transfer for four cycles, so queued writes have drained
   task automatic ap_idle();
      k = 0;
      n = 0;
      while (n < 4 && k < 400)
      begin
         @(negedge CLOCK);
         k++;
         n = (AP_REQ === 1'b0) ? n + 1 : 0;
      end
      if (n < 4)
         timeout();
   endtask : ap_idle
   initial
   begin
      seed = 32'h1698;
      fail_count = 0;
      n_compared = 0;
      RST_B = 1'b0;
      AVS_ADDRESS = 5'h00;
      AVS_READ = 1'b0;
      AVS_WRITE = 1'b0;
      AVS_WRITEDATA = 32'h0000_0000;
      AVS_BYTEENABLE = 4'hF;
      AP_DONE = 1'b0;
      AP_ERR = 1'b0;
      AP_RDATA = 32'h0000_0000;
      ap_stall = 1'b0;
      ap_err = 1'b0;
      ap_wait = 0;
      repeat (5) @(posedge CLOCK);
      RST_B <= 1'b1;
      @(negedge CLOCK);
      check({29'h0, ACK}, {29'h0, A_OK});
      check({31'h0, IRQ}, 32'h0000_0000);
      av(1'b0, `SWB_OFS_CONFIG, 32'h0000_0000, q);
      check(q, 32'h0000_0004);
      av(1'b0, 5'h14, 32'h0000_0000, q);
      check(q, 32'h0000_0000);
      av(1'b1, `SWB_OFS_IRQ_ENABLE, 32'h0000_0001, q);
      $display("test reset done");
      ap_stall = 1'b1;
      repeat (4) req(1'b1, 1'b0, 2'h1, $random(seed), A_OK);
      req(1'b1, 1'b1, 2'h1, 32'h0000_0000, A_WT);
      req(1'b0, 1'b0, 2'h2, 32'h0000_0000, A_WT);
      req(1'b0, 1'b1, 2'h0, 32'h0000_0000, A_OK);
      check(host.got_data, `SWB_IDENT_VALUE);
      st(32'h0000_0701, 32'h0000_0001);
      check({31'h0, IRQ}, 32'h0000_0001);
      req(1'b0, 1'b1, 2'h3, 32'h0000_0000, A_FT);
      st(32'h0000_0008, 32'h0000_0000);
      req(1'b0, 1'b1, 2'h1, 32'h0000_0000, A_OK);
      ap_stall = 1'b0;
      ap_idle();
      req(1'b0, 1'b0, 2'h0, 32'h0000_0008, A_OK);
      st(32'h0000_0001, 32'h0000_0000);
      av(1'b1, `SWB_OFS_IRQ_CLEAR, 32'h0000_0007, q);
      repeat (2) @(negedge CLOCK);
      check({31'h0, IRQ}, 32'h0000_0000);
      $display("test flush done");
      ap_stall = 1'b1;
      repeat (2) req(1'b1, 1'b0, 2'h0, $random(seed), A_OK);
      req(1'b0, 1'b0, 2'h0, 32'h0000_0000, A_OK);
      st(32'h0000_0001, 32'h0000_0001);
      ap_stall = 1'b0;
      ap_idle();
      req(1'b0, 1'b0, 2'h0, 32'h0000_0008, A_OK);
      ap_stall = 1'b1;
      repeat (3) req(1'b1, 1'b0, 2'h0, $random(seed), A_OK);
      ap_err = 1'b1;
      ap_stall = 1'b0;
      ap_idle();
      ap_err = 1'b0;
      st(32'h0000_0703, st_exp(1'b1, 1'b1));
      req(1'b0, 1'b0, 2'h0, 32'h0000_000C, A_OK);
      st(32'h0000_0003, st_exp(1'b0, 1'b0));
      $display("test abandon done");
      req(1'b1, 1'b1, 2'h1, 32'h0000_0000, A_OK);
      ap_idle();
      r1 = ap_res;
      req(1'b1, 1'b1, 2'h1, 32'h0000_0000, A_OK);
      check(host.got_data, r1);
      ap_idle();
      req(1'b0, 1'b1, 2'h3, 32'h0000_0000, A_OK);
      check(host.got_data, ap_res);
      st(32'h0000_0008, 32'h0000_0008);
      req(1'b0, 1'b1, 2'h2, 32'h0000_0000, A_OK);
      check(host.got_data, ap_res);
      req(1'b0, 1'b0, 2'h2, 32'h0000_0001, A_OK);
      req(1'b0, 1'b1, 2'h1, 32'h0000_0000, A_OK);
      check(host.got_data, 32'h0000_0001);
      req(1'b0, 1'b0, 2'h2, 32'h0000_0000, A_OK);
      av(1'b1, `SWB_OFS_CONFIG, 32'h0000_0005, q);
      req(1'b1, 1'b0, 2'h1, 32'hFFFF_0000, A_OK);
      ap_idle();
      check({31'h0, last_rnw}, 32'h0000_0001);
      av(1'b1, `SWB_OFS_CONFIG, 32'h0000_0006, q);
      ap_stall = 1'b1;
      req(1'b1, 1'b1, 2'h0, 32'h0000_0000, A_OK);
      req(1'b0, 1'b1, 2'h3, 32'h0000_0000, A_WT);
      check({31'h0, host.got_dp}, 32'h0000_0001);
      st(32'h0000_0008, 32'h0000_0000);
      req(1'b1, 1'b1, 2'h0, 32'h0000_0000, A_FT);
      check({31'h0, host.got_dp}, 32'h0000_0001);
      ap_stall = 1'b0;
      ap_idle();
      req(1'b0, 1'b0, 2'h0, 32'h0000_0010, A_OK);
      st(32'h0000_0004, 32'h0000_0000);
      av(1'b1, `SWB_OFS_CONFIG, 32'h0000_0004, q);
      av(1'b0, `SWB_OFS_IRQ_STATUS, 32'h0000_0000, q);
      check(q & 32'h0000_0006, 32'h0000_0006);
      $display("test data paths done");
      for (int i = 0; i < 10; i++)
      begin
         wq.delete();
         eq.delete();
         repeat (1 + $unsigned($random(seed)) % 4)
         begin
            r1 = $random(seed);
            eq.push_back(r1);
            req(1'b1, 1'b0, r1[1:0], r1, A_OK);
         end
         // Stallable write first, so nothing buffered is lost
         k = 0;
         do
         begin
            host.xfer(1'b0, 1'b0, 2'h2, 32'h0000_0000, ok);
            k++;
         end
         while (host.got_ack !== A_OK && k < 30);
         if (!ok || host.got_ack !== A_OK)
            timeout();
         check(32'(wq.size()), 32'(eq.size()));
         foreach (eq[m])
            check(wq[m], eq[m]);
      end
      $display("test order done");
      print_verdict();
   end
endmodule : swb_top_tb
